// ### index_branch_and_boolean_unit.sv
// execute stage for index-compare branches and operand-register boolean ops
`default_nettype none
// What this block does
// - branch word: opcode, two index selects, target
// - taken branch redirects fetch to target
// - equal on every bit; opcode 05 inverts
// - all zeros and all ones differ
// - signed compare, ge taken, 07 on less
// - positive zero ranks above negative zero
// - variant flushes stack on taken stack branch
// - opcode 10 copies j operand unchanged
// - opcode 11 writes j AND k
// - opcode 12 writes j OR k
// - opcode 13 writes j XOR k
// - opcode 14 writes complement of k
// - opcode 15 writes j AND NOT k
// - opcode 16 writes j OR NOT k
// - each result bit uses only same-position bits
// - index regs one's complement, bit 17 sign
module index_branch_and_boolean_unit (
    // clock and reset
    input  wire logic                        CORE_CLK_IN,
    input  wire logic                        SYS_RST_IN,
    // configuration
    input  wire logic                        STACK_VARIANT_IN,
    // instruction issue
    input  wire logic                        INSTR_VALID_IN,
    input  wire logic [ibu_pkg::WORD_W-1:0]  INSTR_IN,
    input  wire logic                        INSTR_FROM_STACK_IN,
    output logic                             INSTR_READY_OUT,
    // index register load
    input  wire logic                        IDX_WR_EN_IN,
    input  wire logic [ibu_pkg::SEL_W-1:0]   IDX_WR_SEL_IN,
    input  wire logic [ibu_pkg::IDX_W-1:0]   IDX_WR_DATA_IN,
    // operand register load
    input  wire logic                        OPR_WR_EN_IN,
    input  wire logic [ibu_pkg::SEL_W-1:0]   OPR_WR_SEL_IN,
    input  wire logic [ibu_pkg::OPR_W-1:0]   OPR_WR_DATA_IN,
    output logic                             OPR_WR_READY_OUT,
    // completion and branch outcome
    output logic                             DONE_OUT,
    output logic                             REDIRECT_OUT,
    output logic                             CONTINUE_OUT,
    output logic                             STACK_FLUSH_OUT,
    output logic      [ibu_pkg::IDX_W-1:0]   TARGET_OUT,
    // boolean result
    output logic                             RESULT_VALID_OUT,
    output logic      [ibu_pkg::SEL_W-1:0]   RESULT_SEL_OUT,
    output logic      [ibu_pkg::OPR_W-1:0]   RESULT_DATA_OUT
);
    localparam int IW = ibu_pkg::IDX_W;
    localparam int OW = ibu_pkg::OPR_W;
    localparam int SW = ibu_pkg::SEL_W;

    // ---------------- issue decode ----------------
    ibu_pkg::instr_t in_dec;
    assign in_dec.opcode_field = INSTR_IN[ibu_pkg::OPC_HI:ibu_pkg::OPC_LO];
    assign in_dec.sel_a        = INSTR_IN[ibu_pkg::SELA_HI:ibu_pkg::SELA_LO];
    assign in_dec.sel_b        = INSTR_IN[ibu_pkg::SELB_HI:ibu_pkg::SELB_LO];
    assign in_dec.sel_c        = INSTR_IN[ibu_pkg::SELC_HI:ibu_pkg::SELC_LO];
    assign in_dec.target       = INSTR_IN[ibu_pkg::TGT_HI:ibu_pkg::TGT_LO];
    assign in_dec.from_stack   = INSTR_FROM_STACK_IN;

    wire in_is_branch = (in_dec.opcode_field >= ibu_pkg::OP_BR_EQ) &&
                        (in_dec.opcode_field <= ibu_pkg::OP_BR_LT);

    // one instruction in flight: the next read follows the previous write-back,
    // which avoids a bypass path at the cost of one issue every two cycles
    logic exec_v_r;
    wire  take = INSTR_VALID_IN && !exec_v_r;
    assign INSTR_READY_OUT = !exec_v_r;

    // each instruction reads only the file it needs, so a branch never toggles
    // the wide operand read registers and a boolean op never the index ones
    wire idx_rd_en = take && in_is_branch;
    wire opr_rd_en = take && !in_is_branch;

    ibu_pkg::instr_t exec_r;

    // the variant strap is a pin from outside the clock domain: two flops before use;
    // a strap change therefore lands two cycles late, which is harmless for a strap
    logic variant_meta_r;
    logic variant_r;
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            variant_meta_r <= 1'b0;
        end else begin
            variant_meta_r <= STACK_VARIANT_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            variant_r <= 1'b0;
        end else begin
            variant_r <= variant_meta_r;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            exec_v_r <= 1'b0;
        end else begin
            exec_v_r <= take;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            exec_r <= '0;
        end else if (take) begin
            exec_r <= in_dec;
        end
    end

    // ---------------- register files ----------------
    // branches read index regs a,b; boolean ops read operand regs j=b, k=c
    logic [IW-1:0] first_index_reg;
    logic [IW-1:0] second_index_reg;
    logic [OW-1:0] first_operand_reg;
    logic [OW-1:0] second_operand_reg;

    ibu_regfile #(
        .WIDTH (IW),
        .DEPTH (ibu_pkg::NREG),
        .SELW  (SW),
        .RST   (ibu_pkg::IDX_RST)
    ) u_index_regs (
        .clk       (CORE_CLK_IN),
        .rst       (SYS_RST_IN),
        .wr_en     (IDX_WR_EN_IN),
        .wr_sel    (IDX_WR_SEL_IN),
        .wr_data   (IDX_WR_DATA_IN),
        .rd_en     (idx_rd_en),
        .rd_a_sel  (in_dec.sel_a),
        .rd_b_sel  (in_dec.sel_b),
        .rd_a_data (first_index_reg),
        .rd_b_data (second_index_reg)
    );

    wire           bool_wr;
    wire [OW-1:0]  bool_res;
    wire           opr_wr_en   = bool_wr || OPR_WR_EN_IN;
    wire [SW-1:0]  opr_wr_sel  = bool_wr ? exec_r.sel_a : OPR_WR_SEL_IN;
    wire [OW-1:0]  opr_wr_data = bool_wr ? bool_res : OPR_WR_DATA_IN;

    // write-back of a boolean result takes the port; an outside load waits
    assign OPR_WR_READY_OUT = !bool_wr;

    ibu_regfile #(
        .WIDTH (OW),
        .DEPTH (ibu_pkg::NREG),
        .SELW  (SW),
        .RST   (ibu_pkg::OPR_RST)
    ) u_operand_regs (
        .clk       (CORE_CLK_IN),
        .rst       (SYS_RST_IN),
        .wr_en     (opr_wr_en),
        .wr_sel    (opr_wr_sel),
        .wr_data   (opr_wr_data),
        .rd_en     (opr_rd_en),
        .rd_a_sel  (in_dec.sel_b),
        .rd_b_sel  (in_dec.sel_c),
        .rd_a_data (first_operand_reg),
        .rd_b_data (second_operand_reg)
    );

    // ---------------- branch tests ----------------
    wire [ibu_pkg::OPC_W-1:0] op = exec_r.opcode_field;
    wire is_eq  = (op == ibu_pkg::OP_BR_EQ);
    wire is_ne  = (op == ibu_pkg::OP_BR_NE);
    wire is_ge  = (op == ibu_pkg::OP_BR_GE);
    wire is_lt  = (op == ibu_pkg::OP_BR_LT);
    wire is_br  = is_eq || is_ne || is_ge || is_lt;

    // plain bit compare, so +0 and -0 stay distinct
    wire idx_same = (first_index_reg == second_index_reg);
    // the top bit is the sign; within one sign the raw one's-complement patterns
    // already sort in numeric order, so only a sign mismatch needs handling,
    // and -0 (all ones) ends up just below +0 (all zeros)
    wire idx_sign_a = first_index_reg[IW-1];
    wire idx_sign_b = second_index_reg[IW-1];
    wire idx_mag_ge = (first_index_reg >= second_index_reg);
    wire idx_ge     = (idx_sign_a != idx_sign_b) ? !idx_sign_a : idx_mag_ge;

    wire br_taken = (is_eq && idx_same)  ||
                    (is_ne && !idx_same) ||
                    (is_ge && idx_ge)    ||
                    (is_lt && !idx_ge);

    ibu_pkg::branch_t br_nxt;
    assign br_nxt.redirect    = exec_v_r && is_br && br_taken;
    assign br_nxt.cont        = exec_v_r && is_br && !br_taken;
    assign br_nxt.flush_stack = exec_v_r && is_br && br_taken &&
                                variant_r && exec_r.from_stack;
    assign br_nxt.target      = exec_r.target;

    // ---------------- boolean ops ----------------
    ibu_pkg::bool_fn_t fn;
    logic              fn_ok;
    always_comb begin
        fn    = ibu_pkg::FN_XMIT;
        fn_ok = 1'b1;
        unique case (op)
            ibu_pkg::OP_XMIT: fn = ibu_pkg::FN_XMIT;
            ibu_pkg::OP_AND:  fn = ibu_pkg::FN_AND;
            ibu_pkg::OP_OR:   fn = ibu_pkg::FN_OR;
            ibu_pkg::OP_XOR:  fn = ibu_pkg::FN_XOR;
            ibu_pkg::OP_CMPL: fn = ibu_pkg::FN_CMPL;
            ibu_pkg::OP_ANDN: fn = ibu_pkg::FN_ANDN;
            ibu_pkg::OP_ORN:  fn = ibu_pkg::FN_ORN;
            default:          fn_ok = 1'b0;
        endcase
    end

    ibu_bool_unit #(
        .WIDTH (OW)
    ) u_bool (
        .src_j  (first_operand_reg),
        .src_k  (second_operand_reg),
        .fn     (fn),
        .result (bool_res)
    );

    // branches never reach the operand write port
    assign bool_wr = exec_v_r && fn_ok;

    // ---------------- registered outputs ----------------
    ibu_pkg::branch_t br_r;
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            br_r <= '0;
        end else begin
            br_r <= br_nxt;
        end
    end

    // every issued word, illegal opcodes too, reports completion so fetch never stalls
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            DONE_OUT <= 1'b0;
        end else begin
            DONE_OUT <= exec_v_r;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            RESULT_VALID_OUT <= 1'b0;
        end else begin
            RESULT_VALID_OUT <= bool_wr;
        end
    end

    // result fields hold the last write-back until the next one
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            RESULT_SEL_OUT  <= '0;
            RESULT_DATA_OUT <= ibu_pkg::OPR_RST;
        end else if (bool_wr) begin
            RESULT_SEL_OUT  <= exec_r.sel_a;
            RESULT_DATA_OUT <= bool_res;
        end
    end

    assign REDIRECT_OUT    = br_r.redirect;
    assign CONTINUE_OUT    = br_r.cont;
    assign STACK_FLUSH_OUT = br_r.flush_stack;
    assign TARGET_OUT      = br_r.target;
endmodule : index_branch_and_boolean_unit
`default_nettype wire

// ### ibu_pkg.sv
// shared constants and field layouts for the index branch and boolean unit
`default_nettype none
package ibu_pkg;
    localparam int IDX_W   = 18;
    localparam int OPR_W   = 60;
    localparam int SEL_W   = 3;
    localparam int NREG    = 8;
    localparam int WORD_W  = 30;
    localparam int OPC_W   = 6;

    // field positions within the 30-bit window; a one-parcel word sits in bits 29:15
    localparam int OPC_HI  = 29;
    localparam int OPC_LO  = 24;
    localparam int SELA_HI = 23;
    localparam int SELA_LO = 21;
    localparam int SELB_HI = 20;
    localparam int SELB_LO = 18;
    localparam int SELC_HI = 17;
    localparam int SELC_LO = 15;
    localparam int TGT_HI  = 17;
    localparam int TGT_LO  = 0;

    // reset values
    localparam logic [IDX_W-1:0] IDX_RST = 18'h00000;
    localparam logic [OPR_W-1:0] OPR_RST = 60'h000000000000000;

    // opcode values (octal 04..07 and 10..16 written in hex)
    typedef enum logic [OPC_W-1:0] {
        OP_BR_EQ  = 6'h04,
        OP_BR_NE  = 6'h05,
        OP_BR_GE  = 6'h06,
        OP_BR_LT  = 6'h07,
        OP_XMIT   = 6'h08,
        OP_AND    = 6'h09,
        OP_OR     = 6'h0A,
        OP_XOR    = 6'h0B,
        OP_CMPL   = 6'h0C,
        OP_ANDN   = 6'h0D,
        OP_ORN    = 6'h0E
    } opcode_t;

    // boolean function selector for the bit-slice unit
    typedef enum logic [2:0] {
        FN_XMIT = 3'h0,
        FN_AND  = 3'h1,
        FN_OR   = 3'h2,
        FN_XOR  = 3'h3,
        FN_CMPL = 3'h4,
        FN_ANDN = 3'h5,
        FN_ORN  = 3'h6
    } bool_fn_t;

    // decoded instruction carried from issue into the execute stage
    typedef struct packed {
        logic [OPC_W-1:0] opcode_field;
        logic [SEL_W-1:0] sel_a;
        logic [SEL_W-1:0] sel_b;
        logic [SEL_W-1:0] sel_c;
        logic [IDX_W-1:0] target;
        logic             from_stack;
    } instr_t;

    // branch outcome presented to the fetch logic
    typedef struct packed {
        logic             redirect;
        logic             cont;
        logic             flush_stack;
        logic [IDX_W-1:0] target;
    } branch_t;
endpackage : ibu_pkg
`default_nettype wire

// ### ibu_regfile.sv
// small register file with two registered read ports and one write port
`default_nettype none
module ibu_regfile #(
    parameter int                 WIDTH = 18,
    parameter int                 DEPTH = 8,
    parameter int                 SELW  = 3,
    parameter logic [WIDTH-1:0]   RST   = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // write port
    input  wire logic             wr_en,
    input  wire logic [SELW-1:0]  wr_sel,
    input  wire logic [WIDTH-1:0] wr_data,
    // read ports
    input  wire logic             rd_en,
    input  wire logic [SELW-1:0]  rd_a_sel,
    input  wire logic [SELW-1:0]  rd_b_sel,
    output logic      [WIDTH-1:0] rd_a_data,
    output logic      [WIDTH-1:0] rd_b_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            wire hit = wr_en && (wr_sel == SELW'(g));
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_r[g] <= RST;
                end else if (hit) begin
                    mem_r[g] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_a_data <= RST;
            rd_b_data <= RST;
        end else if (rd_en) begin
            rd_a_data <= mem_r[rd_a_sel];
            rd_b_data <= mem_r[rd_b_sel];
        end
    end
endmodule : ibu_regfile
`default_nettype wire

// ### ibu_bool_unit.sv
// bit-slice boolean unit: every result bit sees only its own two source bits
`default_nettype none
module ibu_bool_unit #(
    parameter int WIDTH = 60
) (
    input  wire logic [WIDTH-1:0] src_j,
    input  wire logic [WIDTH-1:0] src_k,
    input  wire ibu_pkg::bool_fn_t fn,
    output logic      [WIDTH-1:0] result
);
    genvar b;
    generate
        // one slice per bit, no carry between slices
        for (b = 0; b < WIDTH; b++) begin : g_bit
            wire j = src_j[b];
            wire k = src_k[b];
            assign result[b] = (fn == ibu_pkg::FN_XMIT) ? j :
                               (fn == ibu_pkg::FN_AND)  ? (j & k) :
                               (fn == ibu_pkg::FN_OR)   ? (j | k) :
                               (fn == ibu_pkg::FN_XOR)  ? (j ^ k) :
                               (fn == ibu_pkg::FN_CMPL) ? ~k :
                               (fn == ibu_pkg::FN_ANDN) ? (j & ~k) :
                               (j | ~k);
        end
    endgenerate
endmodule : ibu_bool_unit
`default_nettype wire

// ### ibu_monitor.sv
// assertion checker for the index branch and boolean unit
`default_nettype none
module ibu_chk (
    input wire logic        CORE_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        STACK_VARIANT_IN,
    input wire logic        INSTR_VALID_IN,
    input wire logic [29:0] INSTR_IN,
    input wire logic        INSTR_FROM_STACK_IN,
    input wire logic        INSTR_READY_OUT,
    input wire logic        OPR_WR_READY_OUT,
    input wire logic        DONE_OUT,
    input wire logic        REDIRECT_OUT,
    input wire logic        CONTINUE_OUT,
    input wire logic        STACK_FLUSH_OUT,
    input wire logic [17:0] TARGET_OUT,
    input wire logic        RESULT_VALID_OUT,
    input wire logic [2:0]  RESULT_SEL_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic take;
    wire logic brx;
    assign take = INSTR_VALID_IN && INSTR_READY_OUT;
    assign brx  = REDIRECT_OUT || CONTINUE_OUT;
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    a_done_after_take: assert property (take |-> ##2 DONE_OUT) else $error("no done two edges after take");
    a_busy_after_take: assert property (take |=> !INSTR_READY_OUT) else $error("ready high after take");
    a_branch_decode: assert property (brx |-> DONE_OUT && $past(INSTR_IN[29:24], 2) inside {[6'h04:6'h07]})
        else $error("branch outcome for non-branch opcode");
    a_one_outcome: assert property (!(REDIRECT_OUT && CONTINUE_OUT)) else $error("taken and untaken together");
    a_target_field: assert property (brx |-> TARGET_OUT == $past(INSTR_IN[17:0], 2))
        else $error("target not from low 18 bits");
    a_flush_cause: assert property (STACK_FLUSH_OUT |-> REDIRECT_OUT && $past(INSTR_FROM_STACK_IN, 2))
        else $error("flush without taken stack branch");
    a_flush_due: assert property (REDIRECT_OUT && $past(INSTR_FROM_STACK_IN, 2)
        && $past(STACK_VARIANT_IN, 2) && $past(STACK_VARIANT_IN, 3) && $past(STACK_VARIANT_IN, 4)
        |-> STACK_FLUSH_OUT)
        else $error("missing stack flush");
    a_result_dest: assert property (RESULT_VALID_OUT |-> DONE_OUT
        && RESULT_SEL_OUT == $past(INSTR_IN[23:21], 2) && $past(INSTR_IN[29:24], 2) inside {[6'h08:6'h0E]})
        else $error("bad result select");
    a_wb_stall: assert property (!OPR_WR_READY_OUT |=> RESULT_VALID_OUT) else $error("stall without result");
    a_bool_no_branch: assert property (RESULT_VALID_OUT |-> !brx) else $error("boolean op gave branch");

    c_taken: cover property (REDIRECT_OUT);
    c_untaken: cover property (CONTINUE_OUT);
    c_flush: cover property (STACK_FLUSH_OUT);
    c_result: cover property (RESULT_VALID_OUT);
endmodule : ibu_chk

bind index_branch_and_boolean_unit ibu_chk ibu_chk_inst (
    .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .STACK_VARIANT_IN(STACK_VARIANT_IN),
    .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .INSTR_FROM_STACK_IN(INSTR_FROM_STACK_IN),
    .INSTR_READY_OUT(INSTR_READY_OUT), .OPR_WR_READY_OUT(OPR_WR_READY_OUT), .DONE_OUT(DONE_OUT),
    .REDIRECT_OUT(REDIRECT_OUT), .CONTINUE_OUT(CONTINUE_OUT), .STACK_FLUSH_OUT(STACK_FLUSH_OUT),
    .TARGET_OUT(TARGET_OUT), .RESULT_VALID_OUT(RESULT_VALID_OUT), .RESULT_SEL_OUT(RESULT_SEL_OUT)
);
`default_nettype wire

// ### ibu_fetch_model.sv
// fetch side model: offers one instruction at a time and tracks the fetch address
`default_nettype none
module ibu_fetch_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        go_in,
    input  wire logic [29:0] word_in,
    input  wire logic        stk_in,
    input  wire logic        ready_in,
    input  wire logic        redirect_in,
    input  wire logic        cont_in,
    input  wire logic [17:0] target_in,
    output logic             valid_out,
    output logic      [29:0] instr_out,
    output logic             stk_out,
    output logic      [17:0] pc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // released fields flip so a stale word can never pass for a fresh one
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            instr_out <= 30'h3FFFFFFF;
            stk_out   <= 1'b0;
        end else if (go_in) begin
            valid_out <= 1'b1;
            instr_out <= word_in;
            stk_out   <= stk_in;
        end else if (valid_out && ready_in) begin
            valid_out <= 1'b0;
            instr_out <= ~instr_out;
            stk_out   <= ~stk_out;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pc_out <= 18'h00000;
        end else if (redirect_in) begin
            pc_out <= target_in;
        end else if (cont_in) begin
            pc_out <= pc_out + 18'h00001;
        end
    end
endmodule : ibu_fetch_model
`default_nettype wire

// ### tb_index_branch_and_boolean_unit.sv
// self-checking bench for the index branch and boolean unit
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_index_branch_and_boolean_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, variant, go, stk, valid, fstk, ready, iwe, owe, owr_rdy;
    logic        done, redir, cont, flush, rv;
    logic [29:0] word, instr;
    logic [17:0] idat, tgt, pc;
    logic [2:0]  isel, osel, rsel;
    logic [59:0] odat, rdat;
    logic        rdy_c1;
    int          errors, n_checks;

    index_branch_and_boolean_unit index_branch_and_boolean_unit_inst (
        .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .STACK_VARIANT_IN(variant), .INSTR_VALID_IN(valid),
        .INSTR_IN(instr), .INSTR_FROM_STACK_IN(fstk), .INSTR_READY_OUT(ready), .IDX_WR_EN_IN(iwe),
        .IDX_WR_SEL_IN(isel), .IDX_WR_DATA_IN(idat), .OPR_WR_EN_IN(owe), .OPR_WR_SEL_IN(osel),
        .OPR_WR_DATA_IN(odat), .OPR_WR_READY_OUT(owr_rdy), .DONE_OUT(done), .REDIRECT_OUT(redir),
        .CONTINUE_OUT(cont), .STACK_FLUSH_OUT(flush), .TARGET_OUT(tgt), .RESULT_VALID_OUT(rv),
        .RESULT_SEL_OUT(rsel), .RESULT_DATA_OUT(rdat));
    ibu_fetch_model ibu_fetch_model_inst (
        .clk_in(clk), .rst_in(rst), .go_in(go), .word_in(word), .stk_in(stk), .ready_in(ready),
        .redirect_in(redir), .cont_in(cont), .target_in(tgt), .valid_out(valid), .instr_out(instr),
        .stk_out(fstk), .pc_out(pc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    task ldb(input logic [2:0] s, input logic [17:0] v);
        @(posedge clk); iwe <= 1'b1; isel <= s; idat <= v;
        @(posedge clk); iwe <= 1'b0;
    endtask : ldb

    task ldx(input logic [2:0] s, input logic [59:0] v);
        @(posedge clk); owe <= 1'b1; osel <= s; odat <= v;
        @(posedge clk); owe <= 1'b0;
    endtask : ldx

    // offer one word through the fetch model and wait, bounded, for completion
    task issue(input logic [29:0] w, input logic s);
        int i;
        @(posedge clk); go <= 1'b1; word <= w; stk <= s;
        @(posedge clk); go <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk); #1;
            // the operand load port is busy only in the write-back cycle
            if (i == 0) rdy_c1 = owr_rdy;
            if (done === 1'b1) break;
        end
        if (i == 8) begin
            errors++;
            end_sim;
        end
    endtask : issue

    task br(input logic [5:0] op, input logic [17:0] a, input logic [17:0] b, input logic tk, input logic s);
        logic [17:0] p, t;
        p = pc;
        t = a ^ 18'h15555;
        ldb(3'h1, a);
        ldb(3'h2, b);
        issue({op, 3'h1, 3'h2, t}, s);
        `CHK(redir, tk)
        `CHK(cont, !tk)
        `CHK(tgt, t)
        `CHK(flush, tk & s & variant)
        `CHK(rdy_c1, 1'b1)
        @(posedge clk); #1;
        `CHK(pc, tk ? t : p + 18'h00001)
    endtask : br

    task t_equal;
        br(6'h04, 18'h12345, 18'h12345, 1'b1, 1'b0);
        br(6'h04, 18'h00000, 18'h3FFFF, 1'b0, 1'b0);
        br(6'h04, 18'h12345, 18'h12344, 1'b0, 1'b0);
        br(6'h05, 18'h00000, 18'h3FFFF, 1'b1, 1'b0);
        br(6'h05, 18'h2AAAA, 18'h2AAAA, 1'b0, 1'b0);
        br(6'h05, 18'h20000, 18'h00000, 1'b1, 1'b0);
        $display("t_equal done");
    endtask : t_equal

    task t_thresh;
        br(6'h06, 18'h00000, 18'h3FFFF, 1'b1, 1'b0);
        br(6'h07, 18'h00000, 18'h3FFFF, 1'b0, 1'b0);
        br(6'h07, 18'h3FFFF, 18'h00000, 1'b1, 1'b0);
        br(6'h06, 18'h1FFFF, 18'h20000, 1'b1, 1'b0);
        br(6'h07, 18'h20000, 18'h1FFFF, 1'b1, 1'b0);
        br(6'h06, 18'h00005, 18'h00005, 1'b1, 1'b0);
        br(6'h07, 18'h00005, 18'h00005, 1'b0, 1'b0);
        br(6'h07, 18'h3FFFD, 18'h00003, 1'b1, 1'b0);
        $display("t_thresh done");
    endtask : t_thresh

    task t_stack;
        br(6'h04, 18'h00005, 18'h00005, 1'b1, 1'b1);
        br(6'h05, 18'h00005, 18'h00005, 1'b0, 1'b1);
        @(posedge clk); variant <= 1'b0;
        repeat (3) @(posedge clk);
        br(6'h04, 18'h00005, 18'h00005, 1'b1, 1'b1);
        $display("t_stack done");
    endtask : t_stack

    task t_bool;
        logic [59:0] a, b, e;
        int k;
        a = 60'hFF00FF00FF00FF0;
        b = 60'hF0F0F0F0F0F0F0F;
        ldx(3'h1, a);
        ldx(3'h2, b);
        for (k = 0; k < 7; k++) begin
            case (k)
                0: e = a;
                1: e = a & b;
                2: e = a | b;
                3: e = a ^ b;
                4: e = ~b;
                5: e = a & ~b;
                default: e = a | ~b;
            endcase
            issue({6'h08 + k[5:0], 3'h3, 3'h1, 3'h2, 15'h5A5A}, 1'b0);
            `CHK(rv, 1'b1)
            `CHK(rsel, 3'h3)
            `CHK(rdy_c1, 1'b0)
            `CHK(rdat, e)
        end
        // copy the freshly written register straight after its write-back
        issue({6'h08, 3'h4, 3'h3, 3'h0, 15'h0000}, 1'b0);
        `CHK(rdat, a | ~b)
        issue({6'h3F, 3'h5, 3'h1, 3'h2, 15'h0000}, 1'b0);
        `CHK(rv | redir | cont, 1'b0)
        $display("t_bool done");
    endtask : t_bool

    initial begin
        rst = 1'b1; variant = 1'b1; go = 1'b0; word = 30'h00000000; stk = 1'b0;
        iwe = 1'b0; isel = 3'h0; idat = 18'h00000; owe = 1'b0; osel = 3'h0; odat = 60'h000000000000000;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_equal;
        t_thresh;
        t_stack;
        t_bool;
        end_sim;
    end
endmodule : tb_index_branch_and_boolean_unit
`default_nettype wire
